/* File: common/eip_map.svh */
// Constants for the external interrupt pin logic.
// Assumes inclusion by bare name from design and testbench files.
`ifndef EIP_MAP_SVH
`define EIP_MAP_SVH

// Vector types handed to the core
`define EIP_TYPE_NMI 8'h02
`define EIP_TYPE_REQ0 8'h0c
`define EIP_TYPE_REQ1 8'h0d
`define EIP_TYPE_REQ2 8'h0e
`define EIP_TYPE_REQ3 8'h0f
`define EIP_TYPE_REQ4 8'h11
`define EIP_TYPE_NONE 8'h00

// Source indices
`define EIP_SRC_REQ0 3'h0
`define EIP_SRC_REQ1 3'h1
`define EIP_SRC_REQ2 3'h2
`define EIP_SRC_REQ3 3'h3
`define EIP_SRC_REQ4 3'h4
`define EIP_SRC_NMI 3'h5

// Default timing counts in clock cycles
`define EIP_ACK_CYCLES 4
`define EIP_PD_DELAY_CYCLES 16

`endif

/* File: common/eip_pkg.sv */
// Types shared by the external interrupt pin logic.
// Assumes the constant map is on the include path.
package eip_pkg;

  // Sequencer states
  typedef enum logic [1:0] {
    EIP_IDLE,
    EIP_PRESENT,
    EIP_ACK
  } eip_state_type;

  // One driven pin: level and output enable
  typedef struct packed {
    logic out;
    logic oe;
  } eip_pin_type;

  // Vector offered to the core
  typedef struct packed {
    logic valid;
    logic [7:0] vtype;
  } eip_vec_type;

endpackage

/* File: src/eip_prio.sv */
// Fixed priority picker over the maskable external requests.
// Assumes requests are already qualified by mask and pin mode.
`timescale 1ns/100ps
`default_nettype none

module eip_prio #(
  parameter int N = 5
) (
  input wire logic [N-1:0] i_req,
  output logic o_any,
  output logic [2:0] o_idx
);

  logic [N-1:0] lower_taken;
  logic [N-1:0] win;

  // Lowest index wins; each bit knows if a lower one is pending
  genvar g;
  generate
    for (g = 0; g < N; g = g + 1) begin : g_bit
      if (g == 0) begin : g_first
        assign lower_taken[g] = 1'b0;
      end else begin : g_rest
        assign lower_taken[g] = lower_taken[g-1] | i_req[g-1];
      end
      assign win[g] = i_req[g] & ~lower_taken[g];
    end
  endgenerate

  // Encode the single winner
  always_comb begin
    o_idx = 3'h0;
    for (int k = 0; k < N; k++) begin
      if (win[k]) begin
        o_idx = 3'(k);
      end
    end
  end

  assign o_any = |i_req;

endmodule

`default_nettype wire

/* File: src/eip_top.sv */
// External interrupt pin logic: five maskable requests, cascade acknowledge
// pins, latched non-maskable request with powerdown wake.
// Assumes pins are synchronous to i_ref_clk and the core pulses i_cpu_accept
// once for each vector it starts servicing.
//
// Operation
// - Request 0 vectors to type 12, request 1 to type 13.
// - Requests 2, 3 and 4 vector to types 14, 15 and 17.
// - Five requests are active high and maskable; masked ones divert nothing.
// - Cascade mode turns request pins 2 and 3 into acknowledge outputs.
// - Acknowledge 0 goes low as handshake for a served request 0.
// - Acknowledge 1, bidirectional, goes low as handshake for request 1.
// - A rising edge of the non-maskable request yields type 2 regardless of any mask.
// - Non-maskable assertion is latched so short pulses are still served.
// - Non-maskable request ends powerdown; clocks return after the delay.
`timescale 1ns/100ps
`default_nettype none
`include "eip_map.svh"

module eip_top #(
  parameter int ACK_CYCLES = `EIP_ACK_CYCLES,
  parameter int PD_DELAY_CYCLES = `EIP_PD_DELAY_CYCLES
) (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic [4:0] i_ext_request,
  input wire logic [4:0] i_mask,
  input wire logic i_cascade_0,
  input wire logic i_cascade_1,
  input wire logic i_nmi,
  input wire logic i_powerdown_enter,
  input wire logic i_cpu_accept,
  output eip_pkg::eip_vec_type o_vec,
  output eip_pkg::eip_pin_type o_request_ack_0_low,
  output eip_pkg::eip_pin_type o_request_ack_1_low,
  output logic o_clock_enable,
  output logic o_nmi_pending
);

  localparam int CW = 16;

  eip_pkg::eip_state_type state;
  eip_pkg::eip_state_type next_state;
  logic [2:0] src;
  logic [CW-1:0] ack_cnt;
  logic [CW-1:0] pd_cnt;
  logic nmi_prev;
  logic nmi_latch;
  logic pd_waking;

  ////////////////////////////////////////////////////////////////////////////
  // Request qualification and choice

  wire [4:0] pin_is_req = {1'b1, ~i_cascade_1, ~i_cascade_0, 2'b11};
  wire [4:0] live_req = i_ext_request & ~i_mask & pin_is_req;
  wire req_any;
  wire [2:0] req_idx;

  eip_prio #(
    .N(5)
  ) u_prio (
    .i_req(live_req),
    .o_any(req_any),
    .o_idx(req_idx)
  );

  // Vector type lookup per chosen source
  wire [7:0] type_of_idx =
    (req_idx == `EIP_SRC_REQ0) ? `EIP_TYPE_REQ0 :
    (req_idx == `EIP_SRC_REQ1) ? `EIP_TYPE_REQ1 :
    (req_idx == `EIP_SRC_REQ2) ? `EIP_TYPE_REQ2 :
    (req_idx == `EIP_SRC_REQ3) ? `EIP_TYPE_REQ3 :
    `EIP_TYPE_REQ4;

  // Decoded events
  wire nmi_rise = i_nmi & ~nmi_prev;
  wire may_offer = (state == eip_pkg::EIP_IDLE) & o_clock_enable;
  wire offer_nmi = may_offer & nmi_latch;
  wire offer_req = may_offer & ~nmi_latch & req_any;
  wire taken = (state == eip_pkg::EIP_PRESENT) & i_cpu_accept;
  wire nmi_served = taken & (src == `EIP_SRC_NMI);
  wire cascaded_taken = taken & (((src == `EIP_SRC_REQ0) & i_cascade_0) |
                                 ((src == `EIP_SRC_REQ1) & i_cascade_1));
  wire ack_last = (state == eip_pkg::EIP_ACK) & (ack_cnt == CW'(ACK_CYCLES - 1));
  wire pd_done = pd_waking & (pd_cnt == CW'(PD_DELAY_CYCLES - 1));
  wire wake_start = ~o_clock_enable & ~pd_waking & (nmi_latch | nmi_rise);

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  always_comb begin
    next_state = state;
    case (state)
      eip_pkg::EIP_IDLE: begin
        if (offer_nmi | offer_req) begin
          next_state = eip_pkg::EIP_PRESENT;
        end
      end
      eip_pkg::EIP_PRESENT: begin
        if (cascaded_taken) begin
          next_state = eip_pkg::EIP_ACK;
        end else if (taken) begin
          next_state = eip_pkg::EIP_IDLE;
        end
      end
      eip_pkg::EIP_ACK: begin
        if (ack_last) begin
          next_state = eip_pkg::EIP_IDLE;
        end
      end
      default: begin
        next_state = eip_pkg::EIP_IDLE;
      end
    endcase
  end

  // State and chosen source
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state <= eip_pkg::EIP_IDLE;
      src <= `EIP_SRC_REQ0;
    end else begin
      state <= next_state;
      if (offer_nmi) begin
        src <= `EIP_SRC_NMI;
      end else if (offer_req) begin
        src <= req_idx;
      end
    end
  end

  // Vector toward the core, held until accepted
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_vec <= '{valid: 1'b0, vtype: `EIP_TYPE_NONE};
    end else if (offer_nmi) begin
      o_vec <= '{valid: 1'b1, vtype: `EIP_TYPE_NMI};
    end else if (offer_req) begin
      o_vec <= '{valid: 1'b1, vtype: type_of_idx};
    end else if (taken) begin
      o_vec <= '{valid: 1'b0, vtype: `EIP_TYPE_NONE};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Non-maskable latch; a new edge wins over the service clear

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      nmi_prev <= 1'b0;
      nmi_latch <= 1'b0;
    end else begin
      nmi_prev <= i_nmi;
      nmi_latch <= nmi_rise | (nmi_latch & ~nmi_served);
    end
  end

  assign o_nmi_pending = nmi_latch;

  ////////////////////////////////////////////////////////////////////////////
  // Acknowledge pins, driven low for ACK_CYCLES after a cascaded accept

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ack_cnt <= '0;
    end else if (state == eip_pkg::EIP_ACK) begin
      ack_cnt <= ack_cnt + CW'(1);
    end else begin
      ack_cnt <= '0;
    end
  end

  // Pin 2 is a push-pull output in cascade mode; pin 3 drives only while low
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_request_ack_0_low <= '{out: 1'b1, oe: 1'b0};
      o_request_ack_1_low <= '{out: 1'b1, oe: 1'b0};
    end else begin
      o_request_ack_0_low.oe <= i_cascade_0;
      o_request_ack_0_low.out <= ~((next_state == eip_pkg::EIP_ACK) &
                                   (cascaded_taken ? src == `EIP_SRC_REQ0 :
                                    o_request_ack_0_low.oe & ~o_request_ack_0_low.out));
      o_request_ack_1_low.oe <= (next_state == eip_pkg::EIP_ACK) &
                                (cascaded_taken ? src == `EIP_SRC_REQ1 :
                                 o_request_ack_1_low.oe);
      o_request_ack_1_low.out <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Powerdown: clocks stop on entry, return PD_DELAY_CYCLES after a wake

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_clock_enable <= 1'b1;
      pd_waking <= 1'b0;
      pd_cnt <= '0;
    end else begin
      if (pd_done) begin
        o_clock_enable <= 1'b1;
        pd_waking <= 1'b0;
      end else if (wake_start) begin
        pd_waking <= 1'b1;
      end else if (i_powerdown_enter & o_clock_enable & (state == eip_pkg::EIP_IDLE)) begin
        o_clock_enable <= 1'b0;
      end
      pd_cnt <= pd_waking ? pd_cnt + CW'(1) : '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  sequence s_nmi_edge;
    i_nmi & !nmi_prev;
  endsequence

  sequence s_latched;
    ##1 nmi_latch;
  endsequence

  property p_type0;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
      offer_req & (req_idx == `EIP_SRC_REQ0) |=> o_vec.vtype == `EIP_TYPE_REQ0;
  endproperty
  a_type0: assert property (p_type0) else $error("request 0 not type 12");

  property p_type4;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
      offer_req & (req_idx == `EIP_SRC_REQ4) |=> o_vec.vtype == `EIP_TYPE_REQ4;
  endproperty
  a_type4: assert property (p_type4) else $error("request 4 not type 17");

  property p_masked;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
      offer_req |-> ((i_ext_request >> req_idx) & 5'h01) != 5'h00 && !i_mask[req_idx];
  endproperty
  a_masked: assert property (p_masked) else $error("masked request offered");

  property p_cascade_pins;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
      offer_req |-> !((i_cascade_0 && req_idx == `EIP_SRC_REQ2) || (i_cascade_1 && req_idx == `EIP_SRC_REQ3));
  endproperty
  a_cascade_pins: assert property (p_cascade_pins) else $error("ack pin taken as request");

  property p_ack0;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
      taken & i_cascade_0 & (src == `EIP_SRC_REQ0) |=> !o_request_ack_0_low.out [*4] ##1 o_request_ack_0_low.out;
  endproperty
  a_ack0: assert property (p_ack0) else $error("ack 0 pulse wrong");

  property p_ack1;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
      taken & i_cascade_1 & (src == `EIP_SRC_REQ1) |=> o_request_ack_1_low.oe [*4] ##1 !o_request_ack_1_low.oe;
  endproperty
  a_ack1: assert property (p_ack1) else $error("ack 1 pulse wrong");

  property p_nmi_type;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
      offer_nmi |=> o_vec.valid && o_vec.vtype == `EIP_TYPE_NMI;
  endproperty
  a_nmi_type: assert property (p_nmi_type) else $error("nmi not type 2");

  property p_nmi_latch;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
      s_nmi_edge |-> s_latched;
  endproperty
  a_nmi_latch: assert property (p_nmi_latch) else $error("nmi edge not latched");

  property p_wake;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
      wake_start |=> !o_clock_enable ##[1:300] o_clock_enable;
  endproperty
  a_wake: assert property (p_wake) else $error("powerdown wake missing");

  property p_nmi_once;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
      nmi_served & !(i_nmi & !nmi_prev) |=> !nmi_latch;
  endproperty
  a_nmi_once: assert property (p_nmi_once) else $error("nmi latch kept after service");

endmodule

`default_nettype wire

/* File: tb/eip_src_model.sv */
// Model of the external request sources and the cascaded controllers.
// Assumes the bench calls its tasks just after a falling clock edge.
`timescale 1ns/100ps
`default_nettype none

module eip_src_model (
  input wire logic i_ref_clk,
  input wire logic i_cascade_0,
  input wire logic i_cascade_1,
  input wire eip_pkg::eip_pin_type i_ack_0,
  input wire eip_pkg::eip_pin_type i_ack_1,
  output logic [4:0] o_ext_request,
  output logic o_nmi,
  output logic [1:0] o_ack_level
);
  logic [4:0] req = 5'h00;
  initial o_nmi = 1'b0;

  // Pins with pull-ups: a released acknowledge reads high
  assign o_ack_level = {i_ack_1.oe ? i_ack_1.out : 1'b1, i_ack_0.oe ? i_ack_0.out : 1'b1};
  // Shared pins carry the acknowledge level in cascade mode
  assign o_ext_request = {req[4], i_cascade_1 ? o_ack_level[1] : req[3],
    i_cascade_0 ? o_ack_level[0] : req[2], req[1:0]};

  // A cascaded source takes a low acknowledge as confirmation and withdraws
  always @(negedge i_ref_clk) begin
    if (i_cascade_0 && !o_ack_level[0]) req[0] = 1'b0;
    if (i_cascade_1 && !o_ack_level[1]) req[1] = 1'b0;
  end

  // Set the request levels of all five sources
  task automatic set_req(input logic [4:0] v);
    req = v;
  endtask

  // One cycle pulse, shorter than the service delay
  task automatic pulse_nmi();
    o_nmi = 1'b1;
    @(negedge i_ref_clk);
    o_nmi = 1'b0;
  endtask
endmodule

`default_nettype wire

/* File: tb/testbench.sv */
// Self-checking bench for the external interrupt pin logic.
// Assumes the constant map on the include path and the source model beside it.
`timescale 1ns/100ps
`default_nettype none
`include "eip_map.svh"

module testbench;
  localparam int PD = `EIP_PD_DELAY_CYCLES;
  localparam logic [7:0] TYPES [5] = '{`EIP_TYPE_REQ0, `EIP_TYPE_REQ1, `EIP_TYPE_REQ2,
    `EIP_TYPE_REQ3, `EIP_TYPE_REQ4};
  logic i_ref_clk = 1'b0;
  logic i_arst_n = 1'b0;
  logic [4:0] i_mask = 5'h1f;
  logic i_cascade_0 = 1'b0;
  logic i_cascade_1 = 1'b0;
  logic i_powerdown_enter = 1'b0;
  logic i_cpu_accept = 1'b0;
  logic [4:0] ext_request;
  logic nmi;
  logic [1:0] ack_level;
  eip_pkg::eip_vec_type vec;
  eip_pkg::eip_pin_type ack_0;
  eip_pkg::eip_pin_type ack_1;
  logic clock_enable;
  logic nmi_pending;
  int error_cnt = 0;
  int num_checks = 0;
  integer seed = 32'h5686c8ca;
  logic [4:0] live;
  int idx;

  // Clock
  always #5 i_ref_clk = ~i_ref_clk;

  eip_top i_dut (.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n),
    .i_ext_request(ext_request), .i_mask(i_mask), .i_cascade_0(i_cascade_0), .i_cascade_1(i_cascade_1),
    .i_nmi(nmi), .i_powerdown_enter(i_powerdown_enter), .i_cpu_accept(i_cpu_accept), .o_vec(vec),
    .o_request_ack_0_low(ack_0), .o_request_ack_1_low(ack_1), .o_clock_enable(clock_enable),
    .o_nmi_pending(nmi_pending));

  eip_src_model i_src (.i_ref_clk(i_ref_clk), .i_cascade_0(i_cascade_0), .i_cascade_1(i_cascade_1),
    .i_ack_0(ack_0), .i_ack_1(ack_1), .o_ext_request(ext_request), .o_nmi(nmi), .o_ack_level(ack_level));

  ////////////////////////////////////////////////////////////////////////////
  // Lowest set index wins
  function automatic int first_idx(input logic [4:0] v);
    first_idx = 0;
    for (int i = 4; i >= 0; i--) begin
      if (v[i]) first_idx = i;
    end
  endfunction

  // Compare and count
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Wait for a vector, accept it, then watch the acknowledge pin if any
  task automatic serve(input logic [7:0] exp, input logic [4:0] clr, input int ack);
    int n;
    n = 0;
    while (vec.valid !== 1'b1 && n < 40) begin
      @(negedge i_ref_clk);
      n++;
    end
    check(vec.vtype, exp, "vector type");
    i_cpu_accept = 1'b1;
    i_src.set_req(i_src.req & ~clr);
    @(negedge i_ref_clk);
    i_cpu_accept = 1'b0;
    check({7'h00, vec.valid}, 8'h00, "valid after accept");
    for (int k = 1; k <= 5; k++) begin
      if (ack >= 0) check({7'h00, ack_level[ack & 1]}, (k < 5) ? 8'h00 : 8'h01, "acknowledge");
      @(negedge i_ref_clk);
    end
  endtask

  // No vector may be offered for n cycles
  task automatic quiet(input int n);
    repeat (n) begin
      @(negedge i_ref_clk);
      check({7'h00, vec.valid}, 8'h00, "no vector");
    end
  endtask

  // Verdict and end of run
  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog against a hang
  initial begin
    #100000;
    error_cnt++;
    complete_run();
  end

  // Main sequence
  initial begin
    repeat (12) @(posedge i_ref_clk);
    check({6'h00, vec.valid, clock_enable, nmi_pending}, 8'h02, "reset outputs");
    check({6'h00, ack_0}, 8'h02, "ack 0 in reset");
    @(negedge i_ref_clk);
    i_arst_n = 1'b1;
    // Each request alone
    i_mask = 5'h00;
    for (int i = 0; i < 5; i++) begin
      i_src.set_req(5'h01 << i);
      serve(TYPES[i], 5'h01 << i, -1);
    end
    // Random requests and masks, served in priority order
    repeat (8) begin
      live = 5'($random(seed));
      i_mask = 5'($random(seed));
      i_src.set_req(live);
      while ((live & ~i_mask) != 5'h00) begin
        idx = first_idx(live & ~i_mask);
        serve(TYPES[idx], 5'h01 << idx, -1);
        live[idx] = 1'b0;
      end
      quiet(6);
      i_src.set_req(5'h00);
    end
    // Cascade handshakes; shared pins are not requests
    i_mask = 5'h00;
    i_cascade_0 = 1'b1;
    i_cascade_1 = 1'b1;
    repeat (3) @(negedge i_ref_clk);
    i_src.set_req(5'h03);
    serve(`EIP_TYPE_REQ0, 5'h00, 0);
    serve(`EIP_TYPE_REQ1, 5'h00, 1);
    quiet(6);
    i_cascade_0 = 1'b0;
    i_cascade_1 = 1'b0;
    // Short non-maskable pulse with every request masked
    i_mask = 5'h1f;
    i_src.set_req(5'h1f);
    i_src.pulse_nmi();
    repeat (2) @(negedge i_ref_clk);
    check({7'h00, nmi_pending}, 8'h01, "latch set");
    serve(`EIP_TYPE_NMI, 5'h00, -1);
    check({7'h00, nmi_pending}, 8'h00, "latch cleared");
    quiet(8);
    // Powerdown, refused request, wake by non-maskable request
    i_src.set_req(5'h00);
    i_mask = 5'h00;
    i_powerdown_enter = 1'b1;
    @(negedge i_ref_clk);
    i_powerdown_enter = 1'b0;
    check({7'h00, clock_enable}, 8'h00, "clock off");
    i_src.set_req(5'h10);
    quiet(4);
    i_src.pulse_nmi();
    repeat (PD - 1) @(negedge i_ref_clk);
    check({7'h00, clock_enable}, 8'h00, "clock held");
    repeat (1) @(negedge i_ref_clk);
    check({7'h00, clock_enable}, 8'h01, "clock back");
    serve(`EIP_TYPE_NMI, 5'h00, -1);
    serve(`EIP_TYPE_REQ4, 5'h10, -1);
    complete_run();
  end
endmodule

`default_nettype wire
